// [src/counter_serial_readout.sv]
`timescale 1ns/100ps
// Overview of operation
// R1 - Host sends at least 32 preamble ones
// R2 - Read frame: start 01, opcode 10
// R3 - Table bit: 1 counters, 0 memory
// R4 - Host sends seven-bit register address
// R5 - Device drives 32 bits, MSB first, after turnaround
// R6 - Even memory address: word plus one, then word
// R7 - Odd memory address: word, then word minus one
// R8 - Host clocks at least once while idle
// R9 - Clear frame: preamble, start 01, opcode 01
// R10 - Clear acts only on strap address match
// R11 - Scope 1 clears port, 0 one counter
// R12 - Host sends port or counter index
// R13 - Transmit flags: packets 0-8, bytes 9-17
// R14 - Error flags: collisions 0-8, errors 9-17
// R15 - Flags latch on wrap, clear on read
// R16 - Host keeps select low, releases data
module counter_serial_readout (
    input wire logic clk, // 250 MHz system clock
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire logic serialClockPin, // Host serial clock
    input wire logic serialDataPin, // Serial data line level
    input wire logic serialSelectPin, // Select, low during frames
    input wire logic [1:0] chipAddressStrap, // Strapped chip address
    input counter_serial_pkg::ovf_events_t ovfEvents, // Counter wrap pulses
    input wire logic [31:0] statData, // Counter value, one clock after statAddr_r
    input wire logic [15:0] memData, // Memory word, one clock after memAddr_r
    output logic [6:0] statAddr_r, // Counter being read
    output logic [6:0] memAddr_r, // Memory word being read
    output logic serialDataOut_r, // Data driven onto the line
    output logic serialDataOe_r, // High while driving the line
    output counter_serial_pkg::clear_cmd_t clearCmd_r // Clear request pulse
);
    // ============================================================
    // Pin synchronisers
    logic [1:0] clockSync_r;
    logic [1:0] dataSync_r;
    logic [1:0] selSync_r;
    logic [1:0] strapSync0_r;
    logic [1:0] strapSync1_r;
    logic clkPrev_r;
    logic rise;
    logic fall;
    logic din;
    logic sel;
    // Two flops on each pin before any logic looks at it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            clockSync_r <= 2'h0;
            dataSync_r <= 2'h0;
            selSync_r <= 2'h3;
            strapSync0_r <= 2'h0;
            strapSync1_r <= 2'h0;
            clkPrev_r <= 1'h0;
        end else begin
            clockSync_r <= {clockSync_r[0], serialClockPin};
            dataSync_r <= {dataSync_r[0], serialDataPin};
            selSync_r <= {selSync_r[0], serialSelectPin};
            strapSync0_r <= chipAddressStrap;
            strapSync1_r <= strapSync0_r;
            clkPrev_r <= clockSync_r[1];
        end
    end
    // Serial clock edges found on the synchronised level
    assign rise = clockSync_r[1] & ~clkPrev_r;
    assign fall = ~clockSync_r[1] & clkPrev_r;
    assign din = dataSync_r[1];
    assign sel = selSync_r[1];
    // ============================================================
    // Frame decoder
    counter_serial_pkg::state_t state_r;
    logic [5:0] bitCnt_r;
    logic [6:0] shiftIn_r;
    logic table_r;
    logic scope_r;
    logic devMatch_r;
    logic [6:0] fieldNxt;
    logic addrDone;
    logic indexDone;
    assign fieldNxt = {shiftIn_r[5:0], din};
    assign addrDone = rise && state_r == counter_serial_pkg::ST_ADDR
        && bitCnt_r == counter_serial_pkg::ADDR_LAST;
    assign indexDone = rise && state_r == counter_serial_pkg::ST_INDEX
        && bitCnt_r == counter_serial_pkg::INDEX_LAST;
    // Header fields are taken on rising serial clock edges
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= counter_serial_pkg::ST_PREAMBLE;
            bitCnt_r <= 6'h00;
            shiftIn_r <= 7'h00;
            table_r <= 1'h0;
            scope_r <= 1'h0;
            devMatch_r <= 1'h0;
        end else if (sel) begin
            state_r <= counter_serial_pkg::ST_PREAMBLE; // R16
            bitCnt_r <= 6'h00;
        end else if (rise) begin
            unique case (state_r)
                counter_serial_pkg::ST_PREAMBLE: begin
                    if (din && bitCnt_r != counter_serial_pkg::PREAMBLE_FULL) begin
                        bitCnt_r <= bitCnt_r + 6'h01; // R1
                    end else if (!din) begin
                        if (bitCnt_r == counter_serial_pkg::PREAMBLE_FULL) begin
                            state_r <= counter_serial_pkg::ST_START; // R1
                        end
                        bitCnt_r <= 6'h00;
                    end
                end
                counter_serial_pkg::ST_START: begin
                    state_r <= din ? counter_serial_pkg::ST_OPCODE
                                   : counter_serial_pkg::ST_PREAMBLE;
                end
                counter_serial_pkg::ST_OPCODE: begin
                    shiftIn_r <= fieldNxt;
                    if (bitCnt_r == counter_serial_pkg::OPC_LAST) begin
                        bitCnt_r <= 6'h00;
                        if (fieldNxt[1:0] == counter_serial_pkg::OPC_READ) begin
                            state_r <= counter_serial_pkg::ST_TABLE; // R2
                        end else if (fieldNxt[1:0] == counter_serial_pkg::OPC_CLEAR) begin
                            state_r <= counter_serial_pkg::ST_DEVADDR; // R9
                        end else begin
                            state_r <= counter_serial_pkg::ST_PREAMBLE;
                        end
                    end else begin
                        bitCnt_r <= bitCnt_r + 6'h01;
                    end
                end
                counter_serial_pkg::ST_TABLE: begin
                    table_r <= din; // R3
                    state_r <= counter_serial_pkg::ST_ADDR;
                end
                counter_serial_pkg::ST_ADDR: begin
                    shiftIn_r <= fieldNxt; // R4
                    if (addrDone) begin
                        state_r <= counter_serial_pkg::ST_TURN;
                        bitCnt_r <= 6'h00;
                    end else begin
                        bitCnt_r <= bitCnt_r + 6'h01;
                    end
                end
                counter_serial_pkg::ST_TURN: begin
                    if (bitCnt_r == counter_serial_pkg::TURN_LAST) begin
                        state_r <= counter_serial_pkg::ST_DATA;
                        bitCnt_r <= 6'h00;
                    end else begin
                        bitCnt_r <= bitCnt_r + 6'h01;
                    end
                end
                counter_serial_pkg::ST_DATA: begin
                end
                counter_serial_pkg::ST_DEVADDR: begin
                    shiftIn_r <= fieldNxt;
                    if (bitCnt_r == counter_serial_pkg::DEV_LAST) begin
                        state_r <= counter_serial_pkg::ST_SCOPE;
                        bitCnt_r <= 6'h00;
                    end else begin
                        bitCnt_r <= bitCnt_r + 6'h01;
                    end
                end
                counter_serial_pkg::ST_SCOPE: begin
                    scope_r <= din; // R11
                    devMatch_r <= shiftIn_r[1:0] == strapSync1_r; // R10
                    state_r <= counter_serial_pkg::ST_INDEX;
                end
                counter_serial_pkg::ST_INDEX: begin
                    shiftIn_r <= fieldNxt; // R12
                    if (indexDone) begin
                        state_r <= counter_serial_pkg::ST_PREAMBLE; // R8
                        bitCnt_r <= 6'h00;
                    end else begin
                        bitCnt_r <= bitCnt_r + 6'h01;
                    end
                end
            endcase
        end else if (fall && state_r == counter_serial_pkg::ST_DATA) begin
            if (bitCnt_r == counter_serial_pkg::DATA_BITS) begin
                state_r <= counter_serial_pkg::ST_PREAMBLE;
                bitCnt_r <= 6'h00;
            end else begin
                bitCnt_r <= bitCnt_r + 6'h01;
            end
        end
    end
    // ============================================================
    // Read data fetch and output shifter
    counter_serial_pkg::fetch_t fetchPh_r;
    logic [31:0] txShift_r;
    logic [17:0] txFlags_r;
    logic [17:0] errFlags_r;
    logic clrTx;
    logic clrErr;
    logic shiftOut;
    assign clrTx = fetchPh_r == counter_serial_pkg::PH_FIRST && table_r
        && statAddr_r == counter_serial_pkg::OFS_TX_FLAGS;
    assign clrErr = fetchPh_r == counter_serial_pkg::PH_FIRST && table_r
        && statAddr_r == counter_serial_pkg::OFS_ERR_FLAGS;
    assign shiftOut = fall && state_r == counter_serial_pkg::ST_DATA
        && bitCnt_r != counter_serial_pkg::DATA_BITS;
    // Word is gathered during the turnaround, well before the first bit
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fetchPh_r <= counter_serial_pkg::PH_IDLE;
            statAddr_r <= 7'h00;
            memAddr_r <= 7'h00;
            txShift_r <= 32'h00000000;
        end else if (addrDone) begin
            statAddr_r <= fieldNxt;
            memAddr_r <= fieldNxt[0] ? fieldNxt : fieldNxt + 7'h01; // R6 R7
            fetchPh_r <= counter_serial_pkg::PH_WAIT1;
        end else begin
            unique case (fetchPh_r)
                counter_serial_pkg::PH_WAIT1: fetchPh_r <= counter_serial_pkg::PH_FIRST;
                counter_serial_pkg::PH_FIRST: begin
                    if (table_r == counter_serial_pkg::TBL_COUNTERS) begin
                        if (clrTx) begin
                            txShift_r <= {counter_serial_pkg::FLAGS_RSVD, txFlags_r};
                        end else if (clrErr) begin
                            txShift_r <= {counter_serial_pkg::FLAGS_RSVD, errFlags_r};
                        end else begin
                            txShift_r <= statData;
                        end
                        fetchPh_r <= counter_serial_pkg::PH_IDLE;
                    end else begin
                        txShift_r[31:16] <= memData; // R6 R7
                        memAddr_r <= statAddr_r[0] ? statAddr_r - 7'h01 : statAddr_r;
                        fetchPh_r <= counter_serial_pkg::PH_WAIT2;
                    end
                end
                counter_serial_pkg::PH_WAIT2: fetchPh_r <= counter_serial_pkg::PH_SECOND;
                counter_serial_pkg::PH_SECOND: begin
                    txShift_r[15:0] <= memData;
                    fetchPh_r <= counter_serial_pkg::PH_IDLE;
                end
                default: begin
                    if (shiftOut) begin
                        txShift_r <= {txShift_r[30:0], 1'h0}; // R5
                    end
                end
            endcase
        end
    end
    // Line driver: zero in the second turnaround bit, then the word
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            serialDataOut_r <= 1'h0;
            serialDataOe_r <= 1'h0;
        end else if (sel) begin
            serialDataOut_r <= 1'h0;
            serialDataOe_r <= 1'h0;
        end else if (fall) begin
            if (state_r == counter_serial_pkg::ST_TURN
                && bitCnt_r == counter_serial_pkg::TURN_LAST) begin
                serialDataOut_r <= 1'h0;
                serialDataOe_r <= 1'h1;
            end else if (shiftOut) begin
                serialDataOut_r <= txShift_r[31]; // R5
                serialDataOe_r <= 1'h1;
            end else begin
                serialDataOut_r <= 1'h0;
                serialDataOe_r <= 1'h0;
            end
        end
    end
    // ============================================================
    // Overflow flags, a wrap in the clearing cycle still sets
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            txFlags_r <= counter_serial_pkg::FLAGS_RESET;
            errFlags_r <= counter_serial_pkg::FLAGS_RESET;
        end else begin
            txFlags_r <= (txFlags_r & ~{18{clrTx}})
                | {ovfEvents.txByte, ovfEvents.txPkt}; // R13 R15
            errFlags_r <= (errFlags_r & ~{18{clrErr}})
                | {ovfEvents.errCnt, ovfEvents.colCnt}; // R14 R15
        end
    end
    // ============================================================
    // Clear command pulse, withheld when select aborts the frame
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            clearCmd_r <= '0;
        end else begin
            clearCmd_r.valid <= indexDone && devMatch_r && !sel; // R10
            if (indexDone) begin
                clearCmd_r.byPort <= scope_r; // R11
                clearCmd_r.index <= fieldNxt; // R12
            end
        end
    end
    // ============================================================
    // Checks
    sequence seqEvenFirst;
        fetchPh_r == counter_serial_pkg::PH_WAIT1 && !table_r && !statAddr_r[0]
            && memAddr_r == statAddr_r + 7'h01;
    endsequence
    sequence seqOddFirst;
        fetchPh_r == counter_serial_pkg::PH_WAIT1 && !table_r && statAddr_r[0]
            && memAddr_r == statAddr_r;
    endsequence
    AST_EVEN_ORDER: assert property (@(posedge clk) disable iff (sys_rst) // R6
        fetchPh_r == counter_serial_pkg::PH_WAIT1 && !table_r && !statAddr_r[0]
        |-> seqEvenFirst ##2 memAddr_r == statAddr_r)
        else $error("even memory read order wrong");
    AST_ODD_ORDER: assert property (@(posedge clk) disable iff (sys_rst) // R7
        fetchPh_r == counter_serial_pkg::PH_WAIT1 && !table_r && statAddr_r[0]
        |-> seqOddFirst ##2 memAddr_r == statAddr_r - 7'h01)
        else $error("odd memory read order wrong");
    AST_MSB_FIRST: assert property (@(posedge clk) disable iff (sys_rst) // R5
        shiftOut && !sel |=> serialDataOe_r && serialDataOut_r == $past(txShift_r[31]))
        else $error("data bit not taken from word top");
    AST_READ_OPCODE: assert property (@(posedge clk) disable iff (sys_rst) // R2
        rise && !sel && state_r == counter_serial_pkg::ST_OPCODE
        && bitCnt_r == counter_serial_pkg::OPC_LAST && {shiftIn_r[0], din} == 2'h2
        |=> state_r == counter_serial_pkg::ST_TABLE)
        else $error("read opcode not accepted");
    AST_CLEAR_OPCODE: assert property (@(posedge clk) disable iff (sys_rst) // R9
        rise && !sel && state_r == counter_serial_pkg::ST_OPCODE
        && bitCnt_r == counter_serial_pkg::OPC_LAST && {shiftIn_r[0], din} == 2'h1
        |=> state_r == counter_serial_pkg::ST_DEVADDR)
        else $error("clear opcode not accepted");
    AST_TABLE_SEL: assert property (@(posedge clk) disable iff (sys_rst) // R3
        rise && !sel && state_r == counter_serial_pkg::ST_TABLE |=> table_r == $past(din))
        else $error("table select not captured");
    AST_CLEAR_MATCH: assert property (@(posedge clk) disable iff (sys_rst) // R10
        clearCmd_r.valid |-> $past(indexDone && devMatch_r)
        && clearCmd_r.byPort == $past(scope_r))
        else $error("clear issued without address match");
    AST_TX_WRAP: assert property (@(posedge clk) disable iff (sys_rst) // R13
        ovfEvents.txPkt[0] && ovfEvents.txByte[8] |=> txFlags_r[0] && txFlags_r[17])
        else $error("transmit wrap flag missing");
    AST_ERR_WRAP: assert property (@(posedge clk) disable iff (sys_rst) // R14
        ovfEvents.colCnt[8] && ovfEvents.errCnt[3] |=> errFlags_r[8] && errFlags_r[12])
        else $error("error wrap flag missing");
    AST_READ_CLEARS: assert property (@(posedge clk) disable iff (sys_rst) // R15
        clrTx && ovfEvents.txPkt == 9'h000 && ovfEvents.txByte == 9'h000
        |=> txFlags_r == 18'h00000 && txShift_r[31:18] == 14'h0000)
        else $error("flag read did not clear");
endmodule

// [src/counter_serial_pkg.sv]
// ============================================================
// Shared constants and types for the serial counter readout
package counter_serial_pkg;
    // ============================================================
    // Frame layout
    localparam int PREAMBLE_LEN = 32;
    localparam logic [5:0] PREAMBLE_FULL = 6'h20;
    localparam logic [1:0] OPC_READ = 2'h2;
    localparam logic [1:0] OPC_CLEAR = 2'h1;
    localparam int ADDR_W = 7;
    localparam logic [5:0] ADDR_LAST = 6'h06;
    localparam int DEV_W = 2;
    localparam logic [5:0] DEV_LAST = 6'h01;
    localparam int INDEX_W = 7;
    localparam logic [5:0] INDEX_LAST = 6'h06;
    localparam logic [5:0] OPC_LAST = 6'h01;
    localparam logic [5:0] TURN_LAST = 6'h01;
    localparam int DATA_W = 32;
    localparam logic [5:0] DATA_BITS = 6'h20;
    localparam int MEM_W = 16;
    localparam logic TBL_COUNTERS = 1'h1;
    localparam logic SCOPE_PORT = 1'h1;

    // ============================================================
    // Overflow flag registers
    localparam int PORTS = 9;
    localparam int FLAG_W = 18;
    localparam logic [6:0] OFS_TX_FLAGS = 7'h3b;
    localparam logic [6:0] OFS_ERR_FLAGS = 7'h3c;
    localparam logic [17:0] FLAGS_RESET = 18'h00000;
    localparam logic [13:0] FLAGS_RSVD = 14'h0000;

    // ============================================================
    // Fetch sequencer steps
    typedef enum logic [2:0] {
        PH_IDLE, PH_WAIT1, PH_FIRST, PH_WAIT2, PH_SECOND
    } fetch_t;

    typedef enum logic [3:0] {
        ST_PREAMBLE, ST_START, ST_OPCODE, ST_TABLE, ST_ADDR,
        ST_TURN, ST_DATA, ST_DEVADDR, ST_SCOPE, ST_INDEX
    } state_t;

    // Counter wrap pulses, one bit per port, expansion port on bit 8
    typedef struct packed {
        logic [PORTS-1:0] txByte;
        logic [PORTS-1:0] txPkt;
        logic [PORTS-1:0] errCnt;
        logic [PORTS-1:0] colCnt;
    } ovf_events_t;

    // Counter clear request towards the statistics block
    typedef struct packed {
        logic valid;
        logic byPort;
        logic [INDEX_W-1:0] index;
    } clear_cmd_t;
endpackage

// [verification/serial_host_model.sv]
`timescale 1ns/100ps
// ============================================================
// Host controller model driving the serial management link
module serial_host_model (
    input wire logic serialDataOut_r, // Device data bit
    input wire logic serialDataOe_r, // High while the device drives the line
    output logic serialClockPin, // Serial clock towards the device
    output logic serialDataPin, // Resolved level of the data line
    output logic serialSelectPin // Select, low during frames
);
    localparam realtime HALF = 62.5;
    logic hostBit;
    logic hostOe;

    // The line has a pull-up, so a line nobody drives reads high
    assign serialDataPin = serialDataOe_r ? serialDataOut_r : (hostOe ? hostBit : 1'b1);

    // Clock stands low and select low until the first frame
    initial begin
        serialClockPin = 1'b0;
        serialSelectPin = 1'b0;
        hostBit = 1'b1;
        hostOe = 1'b0;
    end

    // One serial clock: set up the bit while low, sample just before the rise
    task automatic clockBit(input logic b, input logic oe, output logic seen);
        hostBit <= b;
        hostOe <= oe;
        #HALF;
        seen = serialDataPin;
        serialClockPin <= 1'b1;
        #HALF;
        serialClockPin <= 1'b0;
    endtask

    // Sends the low n bits of v, most significant first
    task automatic sendBits(input logic [31:0] v, input int n);
        logic s;
        for (int i = n - 1; i >= 0; i--) begin
            clockBit(v[i], 1'b1, s);
        end
    endtask

    // Preamble of pre ones, start pattern, operation code
    task automatic header(input int pre, input logic [1:0] opc);
        sendBits(32'hffffffff, pre);
        sendBits(32'h00000001, 2);
        sendBits({30'h0, opc}, 2);
    endtask

    // Read frame; fewer than 32 data bits aborts it by raising select
    task automatic readFrame(input logic tbl, input logic [6:0] addr, input int nBits,
                             output logic [31:0] data, output logic ta);
        logic s;
        header(32, counter_serial_pkg::OPC_READ);
        sendBits({31'h0, tbl}, 1);
        sendBits({25'h0, addr}, 7);
        clockBit(1'b1, 1'b0, s);
        clockBit(1'b1, 1'b0, ta);
        data = 32'h0;
        for (int i = 31; i >= 32 - nBits; i--) begin
            clockBit(1'b1, 1'b0, s);
            data[i] = s;
        end
        if (nBits < 32) begin
            serialSelectPin <= 1'b1;
            #(4 * HALF);
            serialSelectPin <= 1'b0;
        end
        clockBit(1'b1, 1'b1, s);
    endtask

    // Counter clear frame followed by one idle clock
    task automatic clearFrame(input int pre, input logic [1:0] dev, input logic scope,
                              input logic [6:0] idx);
        logic s;
        header(pre, counter_serial_pkg::OPC_CLEAR);
        sendBits({30'h0, dev}, 2);
        sendBits({31'h0, scope}, 1);
        sendBits({25'h0, idx}, 7);
        clockBit(1'b1, 1'b1, s);
    endtask
endmodule

// [verification/tb.sv]
`timescale 1ns/100ps
// ============================================================
// Self-checking bench for the serial counter readout
module tb;
    logic clk, sys_rst, serialClockPin, serialDataPin, serialSelectPin;
    logic [1:0] chipAddressStrap;
    counter_serial_pkg::ovf_events_t ovfEvents, ev;
    logic [31:0] statData, rd;
    logic [15:0] memData;
    logic [6:0] statAddr_r, memAddr_r, a;
    logic serialDataOut_r, serialDataOe_r, ta;
    counter_serial_pkg::clear_cmd_t clearCmd_r;
    int n_fail = 0;
    int comparisons = 0;
    int nClears = 0;
    logic [6:0] memAddrs [4] = '{7'h00, 7'h03, 7'h7e, 7'h7f};

    // Recognisable contents of counters and memory words
    function automatic logic [31:0] statWord(input logic [6:0] x);
        return {8'h9c, 17'h0, x};
    endfunction
    function automatic logic [15:0] memWord(input logic [6:0] x);
        return {4'hb, 5'h0, x};
    endfunction

    // Statistics block and memory answer at once, well inside one clock
    assign statData = statWord(statAddr_r);
    assign memData = memWord(memAddr_r);

    counter_serial_readout dut_u (.clk(clk), .sys_rst(sys_rst),
        .serialClockPin(serialClockPin), .serialDataPin(serialDataPin),
        .serialSelectPin(serialSelectPin), .chipAddressStrap(chipAddressStrap),
        .ovfEvents(ovfEvents), .statData(statData), .memData(memData),
        .statAddr_r(statAddr_r), .memAddr_r(memAddr_r), .serialDataOut_r(serialDataOut_r),
        .serialDataOe_r(serialDataOe_r), .clearCmd_r(clearCmd_r));

    serial_host_model host_u (.serialDataOut_r(serialDataOut_r),
        .serialDataOe_r(serialDataOe_r), .serialClockPin(serialClockPin),
        .serialDataPin(serialDataPin), .serialSelectPin(serialSelectPin));

    // System clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Counts clock cycles with a clear request raised
    always @(posedge clk) begin
        if (clearCmd_r.valid === 1'b1) begin
            nClears++;
        end
    end

    // Compares one value and counts the outcome
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Full read frame with turnaround, data and release checked
    task automatic readCheck(input logic tbl, input logic [6:0] x, input logic [31:0] exp);
        host_u.readFrame(tbl, x, 32, rd, ta);
        check("turnaround bit", {31'h0, ta}, 32'h0);
        check("read word", rd, exp);
        check("line released", {31'h0, serialDataOe_r}, 32'h0);
    endtask

    // One-cycle wrap pulses on the counter event inputs
    task automatic pulse(input counter_serial_pkg::ovf_events_t e);
        @(posedge clk);
        ovfEvents <= e;
        @(posedge clk);
        ovfEvents <= '0;
    endtask

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        chipAddressStrap = 2'h0;
        ovfEvents = '0;
        repeat (3) @(posedge clk);
        check("oe in reset", {31'h0, serialDataOe_r}, 32'h0);
        check("clear in reset", {23'h0, clearCmd_r}, 32'h0);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        readCheck(1'b1, 7'h16, statWord(7'h16));
        check("counter address", {25'h0, statAddr_r}, 32'h00000016);
        readCheck(1'b1, 7'h7f, statWord(7'h7f));
        foreach (memAddrs[i]) begin
            a = memAddrs[i];
            readCheck(1'b0, a, a[0] ? {memWord(a), memWord(a - 7'h1)} :
                {memWord(a + 7'h1), memWord(a)});
        end
        ev = '0;
        ev.txPkt[0] = 1'b1;
        ev.txByte[8] = 1'b1;
        pulse(ev);
        readCheck(1'b1, counter_serial_pkg::OFS_TX_FLAGS, 32'h00020001);
        readCheck(1'b1, counter_serial_pkg::OFS_TX_FLAGS, 32'h00000000);
        ev = '0;
        ev.colCnt[8] = 1'b1;
        ev.errCnt[3] = 1'b1;
        ev.txByte[0] = 1'b1;
        pulse(ev);
        readCheck(1'b1, counter_serial_pkg::OFS_ERR_FLAGS, 32'h00001100);
        readCheck(1'b1, counter_serial_pkg::OFS_TX_FLAGS, 32'h00000200);
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            chipAddressStrap <= s[1:0];
            repeat (3) @(posedge clk);
            host_u.clearFrame(32, s[1:0], s[0], 7'h40 | 7'(s));
            check("clear pulses", nClears, s + 1);
            check("clear fields", {23'h0, clearCmd_r}, {23'h0, 1'b0, s[0], 7'h40 | 7'(s)});
        end
        host_u.clearFrame(32, 2'h0, 1'b1, 7'h02);
        check("foreign address", nClears, 4);
        // The idle one after the last frame plus 30 makes only 31 ones
        host_u.clearFrame(30, 2'h3, 1'b1, 7'h02);
        check("short preamble", nClears, 4);
        host_u.header(32, 2'h3);
        host_u.sendBits(32'h000003c2, 10);
        check("unknown opcode", nClears, 4);
        host_u.readFrame(1'b1, 7'h16, 8, rd, ta);
        check("partial word", rd, 32'h9c000000);
        check("abort releases", {31'h0, serialDataOe_r}, 32'h0);
        readCheck(1'b1, 7'h20, statWord(7'h20));
        give_verdict();
    end

    // Watchdog against a hung frame
    initial begin
        #350000;
        n_fail++;
        $display("[FAIL] watchdog expired before the tests ended");
        give_verdict();
    end
endmodule
